//--- bench/fsep_cpu_model.sv
// Model of the core issuing stores and interrupts.
`timescale 1ns/1ps
`default_nettype none
// ****
// Core model
// ****
module fsep_cpu_model
  import fsep_pkg::*;
(
  // Clock.
  input wire logic core_clk,
  // Store and interrupt lines.
  output var logic storeReq,
  output var fsep_store_type storeCmd,
  output var logic irqPending
);
  // Idle lines; the store bus carries junk outside requests.
  initial
  begin
    storeReq = 1'b0;
    storeCmd = 24'hA5A5A5;
    irqPending = 1'b0;
  end
  // One store cycle; the bus is inverted afterwards so stale data never looks valid.
  task store(input logic [15:0] a, input logic [7:0] d);
    storeReq <= 1'b1;
    storeCmd <= {a, d};
    @(posedge core_clk);
    storeReq <= 1'b0;
    storeCmd <= ~{a, d};
  endtask : store
  // One cycle of an enabled, pending interrupt.
  task irq;
    irqPending <= 1'b1;
    @(posedge core_clk);
    irqPending <= 1'b0;
  endtask : irq
endmodule : fsep_cpu_model
`default_nettype wire

//--- bench/fsep_tb_top.sv
// Bench for the flash sequencer.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; $display("[ERR] %0t %h %h", $time, a, b); end end
// ****
// Bench
// ****
module fsep_tb_top import fsep_pkg::*;;
  localparam int EC = 20;
  logic core_clk, srst, regWr, regRd, storeReq, irqPending, toolModePin, userMode, eraseBusy;
  logic [7:0] regAddr, regWdata, regRdata;
  fsep_store_type storeCmd;
  fsep_erase_type flashErase;
  fsep_write_type flashWrite;
  int num_errors, checks, cyc, n;
  // Design with a short erase so the run stays brief.
  fsep_top #(.ERASE_CYCLES(EC)) dut_u (.core_clk(core_clk), .srst(srst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .storeReq(storeReq),
    .storeCmd(storeCmd), .irqPending(irqPending), .toolModePin(toolModePin), .flashErase(flashErase),
    .flashWrite(flashWrite), .userMode(userMode), .eraseBusy(eraseBusy));
  fsep_cpu_model cpu_u (.core_clk(core_clk), .storeReq(storeReq), .storeCmd(storeCmd), .irqPending(irqPending));
  // Clock.
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // Hang guard.
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      num_errors++;
      complete_run();
    end
  end
  // Register write with one idle cycle after it, so strobes never collide.
  task wr(input logic [7:0] a, input logic [7:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
    @(posedge core_clk);
  endtask : wr
  // Register read; data stands only in the cycle after the strobe.
  task rdChk(input logic [7:0] a, input logic [7:0] e);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 `CHK(regRdata, e)
    @(posedge core_clk);
  endtask : rdChk
  // Counts busy cycles; the start edge and the write's gap cycle are already busy.
  task waitIdle(output int k);
    k = 2;
    for (int i = 0; i < 100 && eraseBusy; i++)
    begin
      @(posedge core_clk);
      #1 k += eraseBusy;
    end
    @(posedge core_clk);
  endtask : waitIdle
  // Reset values and an unmapped place.
  task tReset;
    `CHK({userMode, eraseBusy}, 2'b00)
    wr(8'h04, 8'hFF);
    for (int a = 0; a < 5; a++)
      rdChk(a[7:0], 8'h00);
  endtask : tReset
  // Full erase with the low sector bits set to ones.
  task tErase;
    wr(8'h00, 8'hA5);
    `CHK(userMode, 1'b1)
    rdChk(8'h00, 8'hA5);
    wr(8'h02, 8'h17);
    wr(8'h03, 8'hFF);
    wr(8'h01, 8'hA1);
    #1 `CHK(flashErase, {1'b1, 9'h02F})
    waitIdle(n);
    `CHK(n, EC)
    rdChk(8'h01, 8'hA0);
  endtask : tErase
  // Interrupt aborts, the retry clears the failure.
  task tAbort;
    wr(8'h01, 8'hA1);
    repeat (5) @(posedge core_clk);
    cpu_u.irq();
    #1 `CHK(eraseBusy, 1'b0)
    @(posedge core_clk);
    rdChk(8'h01, 8'hA8);
    wr(8'h01, 8'hA1);
    rdChk(8'h01, 8'hA1);
    wr(8'h00, 8'h00);
    `CHK({userMode, eraseBusy}, 2'b01)
    waitIdle(n);
    rdChk(8'h01, 8'hA0);
  endtask : tAbort
  // Lock and tool mode refuse the erase; a wrong key leaves user mode off.
  task tLock;
    wr(8'h00, 8'h00);
    wr(8'h01, 8'hA1);
    #1 `CHK({userMode, eraseBusy}, 2'b00)
    @(posedge core_clk);
    wr(8'h00, 8'hA4);
    `CHK(userMode, 1'b0)
    wr(8'h00, 8'hA5);
    toolModePin <= 1'b1;
    repeat (4) @(posedge core_clk);
    wr(8'h01, 8'hA1);
    #1 `CHK({userMode, eraseBusy}, 2'b00)
    @(posedge core_clk);
    toolModePin <= 1'b0;
    repeat (4) @(posedge core_clk);
    `CHK(userMode, 1'b1)
  endtask : tLock
  // Byte program into the erased sector; wrong mode, sector and lock refuse.
  task tProg;
    cpu_u.store(16'h1784, 8'h78);
    #1 `CHK(flashWrite.valid, 1'b0)
    @(posedge core_clk);
    wr(8'h01, 8'h51);
    cpu_u.store(16'h1784, 8'h78);
    #1 `CHK(flashWrite, {1'b1, 16'h1784, 8'h78})
    @(posedge core_clk);
    cpu_u.store(16'h1800, 8'h11);
    #1 `CHK(flashWrite.valid, 1'b0)
    @(posedge core_clk);
    wr(8'h00, 8'h00);
    cpu_u.store(16'h1785, 8'h22);
    #1 `CHK(flashWrite.valid, 1'b0)
    @(posedge core_clk);
    wr(8'h01, 8'h00);
    rdChk(8'h01, 8'h00);
  endtask : tProg
  // Verdict and end of run.
  task complete_run;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run
  // Reset, then the scenarios in order.
  initial
  begin
    srst = 1'b1;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 8'h00;
    regWdata = 8'h00;
    toolModePin = 1'b0;
    repeat (8) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    tReset();
    tErase();
    tAbort();
    tLock();
    tProg();
    complete_run();
  end
endmodule : fsep_tb_top
`default_nettype wire

//--- bench/fsep_top_asserts.sv
// Port checker for the flash sequencer.
`timescale 1ns/1ps
`default_nettype none
`include "fsep_defs.svh"
// ****
// Checker
// ****
module fsep_top_asserts
  import fsep_pkg::*;
#(
  parameter int unsigned ERASE_CYCLES = 20
)
(
  // Clock, reset and register port.
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [`FSEP_ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdata,
  // Core side.
  input wire logic storeReq,
  input wire fsep_store_type storeCmd,
  input wire logic irqPending,
  input wire logic toolModePin,
  // Flash side and status.
  input wire fsep_erase_type flashErase,
  input wire fsep_write_type flashWrite,
  input wire logic userMode,
  input wire logic eraseBusy
);
  logic [12:0] secMode_r;
  int unsigned cnt_r;
  logic ctl;
  logic take;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);
  // Shadow of sector (12:4) and mode (3:0); writes stick even while locked.
  always_ff @(posedge core_clk)
    if (srst)
      secMode_r <= '0;
    else if (regWr && regAddr == `FSEP_OFF_SEC_HIGH)
      secMode_r[12:5] <= regWdata;
    else if (regWr && regAddr == `FSEP_OFF_SEC_LOW)
      secMode_r[4] <= regWdata[7];
    else if (ctl)
      secMode_r[3:0] <= regWdata[7:4];
  // Length of the running erase in cycles.
  always_ff @(posedge core_clk)
    cnt_r <= (srst || !eraseBusy) ? 0 : cnt_r + 1;
  // Control writes and accepted stores.
  assign ctl = regWr && regAddr == `FSEP_OFF_CONTROL;
  assign take = storeReq && userMode && !eraseBusy && secMode_r[3:0] == `FSEP_MODE_PROGRAM
    && storeCmd.addr[15:7] == secMode_r[12:4];
  sequence s_go; ctl && regWdata == `FSEP_CMD_ERASE && userMode && !eraseBusy; endsequence
  property p_start; s_go |=> eraseBusy && flashErase.active && flashErase.sector == secMode_r[12:4]; endproperty
  a_start: assert property (p_start) else $error("erase not started");
  property p_lock; ctl && !userMode && !eraseBusy |=> !eraseBusy; endproperty
  a_lock: assert property (p_lock) else $error("locked erase ran");
  property p_tool; toolModePin [*4] |-> !userMode; endproperty
  a_tool: assert property (p_tool) else $error("user mode in tool mode");
  property p_key; regWr && regAddr == `FSEP_OFF_UNLOCK && regWdata != `FSEP_UNLOCK_KEY |=> !userMode; endproperty
  a_key: assert property (p_key) else $error("wrong key unlocked");
  property p_len; $fell(eraseBusy) && !$past(irqPending) && !$past(srst) |-> cnt_r == ERASE_CYCLES; endproperty
  a_len: assert property (p_len) else $error("erase length wrong");
  property p_abort; eraseBusy && irqPending |=> !eraseBusy && !flashErase.active; endproperty
  a_abort: assert property (p_abort) else $error("erase not aborted");
  property p_store; take |=> flashWrite.valid && flashWrite[23:0] == $past(storeCmd); endproperty
  a_store: assert property (p_store) else $error("store lost");
  property p_quiet; flashWrite.valid |-> $past(take); endproperty
  a_quiet: assert property (p_quiet) else $error("stray write");
endmodule : fsep_top_asserts
bind fsep_top fsep_top_asserts #(.ERASE_CYCLES(ERASE_CYCLES)) chk_u (.core_clk(core_clk), .srst(srst),
  .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
  .storeReq(storeReq), .storeCmd(storeCmd), .irqPending(irqPending), .toolModePin(toolModePin),
  .flashErase(flashErase), .flashWrite(flashWrite), .userMode(userMode), .eraseBusy(eraseBusy));
`default_nettype wire

//--- rtl/fsep_defs.svh
// Constants for the flash sector erase and byte program sequencer.
`ifndef FSEP_DEFS_SVH
`define FSEP_DEFS_SVH

// Register word indices on the plain register port.
`define FSEP_ADDR_W 8
`define FSEP_OFF_UNLOCK 8'h00
`define FSEP_OFF_CONTROL 8'h01
`define FSEP_OFF_SEC_HIGH 8'h02
`define FSEP_OFF_SEC_LOW 8'h03

// Reset values.
`define FSEP_UNLOCK_RST 8'h00
`define FSEP_CONTROL_RST 8'h00
`define FSEP_SEC_RST 8'h00

// Key and command codes.
`define FSEP_UNLOCK_KEY 8'hA5
`define FSEP_CMD_ERASE 8'hA1
`define FSEP_MODE_PROGRAM 4'h5

// Field positions in the operation control register.
`define FSEP_CTL_START_BIT 0
`define FSEP_CTL_FAIL_BIT 3
`define FSEP_CTL_MODE_LSB 4

// Flash geometry.
`define FSEP_SECTOR_COUNT 512
`define FSEP_SECTOR_BYTES 128
`define FSEP_SECTOR_W 9
`define FSEP_SECTOR_LSB 7
`define FSEP_FLASH_ADDR_W 16

// Erase time and its cycle count at the core clock.
`define FSEP_ERASE_TIME_MS 10
`define FSEP_CLK_MHZ 250
`define FSEP_ERASE_CYCLES (`FSEP_ERASE_TIME_MS * 1000 * `FSEP_CLK_MHZ)
`define FSEP_ERASE_CNT_W 22

`endif

//--- rtl/fsep_erase_timer.sv
// Down counter that times one sector erase.
`timescale 1ns/1ps
`default_nettype none
`include "fsep_defs.svh"

module fsep_erase_timer
#(
  parameter int unsigned CYCLES = `FSEP_ERASE_CYCLES
)
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic srst,
  // Control.
  input wire logic load,
  input wire logic halt,
  // Status.
  output logic expired
);

  logic [`FSEP_ERASE_CNT_W-1:0] count_r;

  // ****************************************************
  // Counter
  // ****************************************************

  // Load starts a fresh count; halt drops it so no stale expiry follows an abort.
  always_ff @(posedge core_clk)
  begin
    if (srst || halt)
      count_r <= '0;
    else if (load)
      count_r <= CYCLES[`FSEP_ERASE_CNT_W-1:0];
    else if (count_r != '0)
      count_r <= count_r - 1'b1;
  end

  // Expiry is a one-cycle pulse as the count reaches one.
  assign expired = (count_r == {{(`FSEP_ERASE_CNT_W-1){1'b0}}, 1'b1});

endmodule : fsep_erase_timer
`default_nettype wire

//--- rtl/fsep_pkg.sv
// Types shared by the flash sector erase and byte program sequencer.
package fsep_pkg;

  // Program-memory store issued by the core.
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] data;
  } fsep_store_type;

  // Byte write command handed to the flash array.
  typedef struct packed {
    logic valid;
    logic [15:0] addr;
    logic [7:0] data;
  } fsep_write_type;

  // Erase command handed to the flash array.
  typedef struct packed {
    logic active;
    logic [8:0] sector;
  } fsep_erase_type;

  // Sequencer states, one-hot.
  typedef enum logic [1:0] {
    FSEP_IDLE = 2'b01,
    FSEP_ERASING = 2'b10
  } fsep_state_type;

endpackage : fsep_pkg

//--- rtl/fsep_top.sv
// Flash sector erase and byte program sequencer with its control registers.
`timescale 1ns/1ps
`default_nettype none
`include "fsep_defs.svh"

// Overview of operation
// - Partial erase only in user program mode; a sector is the smallest unit.
// - Flash holds 512 sectors of 128 bytes; erases address whole sectors.
// - An erase is given 10 ms before its sector is touched again, unless an interrupt aborts it first.
// - Sector erase is refused in external tool programming mode.
// - Writing the erase command to the control register starts the erase.
// - Control bit 3 reports erase failure; firmware retries when set.
// - Bytes are written one at a time inside the addressed sector.
// - In program mode a core store writes its byte at its address.
// - Writing the program command selects byte program for the next store.
// - Unlock key resets to zero; only the exact key enables user mode.
// - Control bit 0 starts an erase and is not needed for byte writes; the code starts one only on the whole command word 8'hA1.
// - A pending enabled interrupt aborts the erase; bit 3 then reads one.
// - Bits 6 to 0 of the low sector register are ignored.
module fsep_top
  import fsep_pkg::*;
#(
  parameter int unsigned ERASE_CYCLES = `FSEP_ERASE_CYCLES
)
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic srst,
  // Register port.
  input wire logic [`FSEP_ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  // Program-memory store from the core.
  input wire logic storeReq,
  input wire fsep_store_type storeCmd,
  // Enabled and pending interrupt request from the interrupt controller.
  input wire logic irqPending,
  // Tool programming mode pin.
  input wire logic toolModePin,
  // Flash array commands.
  output fsep_erase_type flashErase,
  output fsep_write_type flashWrite,
  // Status.
  output logic userMode,
  output logic eraseBusy
);

  logic [7:0] unlockKey_r;
  logic [7:0] control_r;
  logic [7:0] secHigh_r;
  logic [7:0] secLow_r;
  logic eraseFail_r;
  logic [7:0] regRdata_r;
  fsep_state_type state_r;
  fsep_state_type state_nxt;
  fsep_write_type flashWrite_r;
  logic [`FSEP_SECTOR_W-1:0] eraseSector_r;
  logic toolSync1_r;
  logic toolSync2_r;
  logic unlocked;
  logic eraseStart;
  logic eraseAbort;
  logic eraseDone;
  logic storeOk;
  logic [`FSEP_SECTOR_W-1:0] sectorSel;

  // ****************************************************
  // Pin synchroniser
  // ****************************************************

  // The tool mode strap comes from a pin, so it passes two flops first.
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      toolSync1_r <= 1'b0;
      toolSync2_r <= 1'b0;
    end
    else
    begin
      toolSync1_r <= toolModePin;
      toolSync2_r <= toolSync1_r;
    end
  end

  // ****************************************************
  // Decodes
  // ****************************************************

  // Only the exact key unlocks, and never while a tool owns the flash.
  assign unlocked = (unlockKey_r == `FSEP_UNLOCK_KEY) && !toolSync2_r;

  // The sector index drops the byte offset bits of the low register.
  assign sectorSel = {secHigh_r, secLow_r[`FSEP_SECTOR_LSB]};

  // An erase starts on the exact command word while unlocked and idle.
  assign eraseStart = regWr && (regAddr == `FSEP_OFF_CONTROL) && (regWdata == `FSEP_CMD_ERASE)
    && unlocked && (state_r == FSEP_IDLE);

  // A pending enabled interrupt cuts the erase short.
  assign eraseAbort = (state_r == FSEP_ERASING) && irqPending;

  // A store writes only in program mode, inside the sector, and not mid-erase.
  assign storeOk = storeReq && unlocked && (state_r == FSEP_IDLE)
    && (control_r[7:`FSEP_CTL_MODE_LSB] == `FSEP_MODE_PROGRAM)
    && (storeCmd.addr[15:`FSEP_SECTOR_LSB] == sectorSel);

  // ****************************************************
  // Erase sequencer
  // ****************************************************

  // Next state for the erase sequencer.
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      FSEP_IDLE:
      begin
        if (eraseStart)
          state_nxt = FSEP_ERASING;
      end
      FSEP_ERASING:
      begin
        if (eraseAbort || eraseDone)
          state_nxt = FSEP_IDLE;
      end
      default:
        state_nxt = FSEP_IDLE;
    endcase
  end

  // State register.
  always_ff @(posedge core_clk)
  begin
    if (srst)
      state_r <= FSEP_IDLE;
    else
      state_r <= state_nxt;
  end

  // The sector is latched at start so a later reload cannot move a running erase.
  always_ff @(posedge core_clk)
  begin
    if (srst)
      eraseSector_r <= '0;
    else if (eraseStart)
      eraseSector_r <= sectorSel;
  end

  // Erase duration timer; the sector stays busy until the erase time runs out or an abort halts it.
  fsep_erase_timer #(
    .CYCLES(ERASE_CYCLES)
  ) u_timer (
    .core_clk(core_clk),
    .srst(srst),
    .load(eraseStart),
    .halt(eraseAbort),
    .expired(eraseDone)
  );

  // Failure flag: set by an abort, cleared only when a new erase starts.
  always_ff @(posedge core_clk)
  begin
    if (srst)
      eraseFail_r <= 1'b0;
    else if (eraseAbort)
      eraseFail_r <= 1'b1;
    else if (eraseStart)
      eraseFail_r <= 1'b0;
  end

  // ****************************************************
  // Software registers
  // ****************************************************

  // Unlock key register.
  always_ff @(posedge core_clk)
  begin
    if (srst)
      unlockKey_r <= `FSEP_UNLOCK_RST;
    else if (regWr && (regAddr == `FSEP_OFF_UNLOCK))
      unlockKey_r <= regWdata;
  end

  // Sector address registers.
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      secHigh_r <= `FSEP_SEC_RST;
      secLow_r <= `FSEP_SEC_RST;
    end
    else if (regWr && (regAddr == `FSEP_OFF_SEC_HIGH))
      secHigh_r <= regWdata;
    else if (regWr && (regAddr == `FSEP_OFF_SEC_LOW))
      secLow_r <= regWdata;
  end

  // Control register; the start bit falls when the erase ends either way.
  always_ff @(posedge core_clk)
  begin
    if (srst)
      control_r <= `FSEP_CONTROL_RST;
    else if (regWr && (regAddr == `FSEP_OFF_CONTROL))
      control_r <= regWdata;
    else if (eraseAbort || eraseDone)
      control_r[`FSEP_CTL_START_BIT] <= 1'b0;
  end

  // Read data stand one cycle after the strobe; unmapped words read zero.
  always_ff @(posedge core_clk)
  begin
    if (srst)
      regRdata_r <= 8'h00;
    else if (regRd)
    begin
      unique case (regAddr)
        `FSEP_OFF_UNLOCK: regRdata_r <= unlockKey_r;
        `FSEP_OFF_CONTROL: regRdata_r <= {control_r[7:4], eraseFail_r, control_r[2:0]};
        `FSEP_OFF_SEC_HIGH: regRdata_r <= secHigh_r;
        `FSEP_OFF_SEC_LOW: regRdata_r <= secLow_r;
        default: regRdata_r <= 8'h00;
      endcase
    end
    else
      regRdata_r <= 8'h00;
  end

  // ****************************************************
  // Byte program
  // ****************************************************

  // One accepted store becomes one registered byte write pulse.
  always_ff @(posedge core_clk)
  begin
    if (srst)
      flashWrite_r <= '0;
    else
    begin
      flashWrite_r.valid <= storeOk;
      if (storeOk)
      begin
        flashWrite_r.addr <= storeCmd.addr;
        flashWrite_r.data <= storeCmd.data;
      end
    end
  end

  // ****************************************************
  // Outputs
  // ****************************************************

  assign regRdata = regRdata_r;
  assign flashWrite = flashWrite_r;
  // The erase command is built in one assignment, so the struct has a single driver.
  assign flashErase = {(state_r == FSEP_ERASING), eraseSector_r};
  assign eraseBusy = (state_r == FSEP_ERASING);
  assign userMode = unlocked;

endmodule : fsep_top
`default_nettype wire
